// ### src/ier_event_router.sv
`timescale 1ns/1ps
// Overview of operation
// - Each request slot picks its source and is routed to CPU or transfer controller.
// - Thirty-three peripheral maskable request inputs are accepted as sources.
// - Each pin detects falling, rising or both edges, one mode per pin.
// - Six external pin inputs, numbered zero to five, are maskable sources.
// - Thirty-nine request outputs are driven toward the CPU vectored controller.
// - Transfer controller requests use the same slot source selection as CPU.
// - Non-maskable pin raises an event on its selected falling or rising edge.
// - Watchdog underflow or refresh error raises a non-maskable event.
// - Voltage monitor one interrupt is delivered as a non-maskable event.
// - SRAM parity fault raises a non-maskable event.
// - In sleep, any non-maskable or any other source requests wake-up.
// - In standby or snooze, non-maskable or enabled sources request wake-up.
// - Each pin's trigger edge comes from its own trigger control input.
module ier_event_router #(
    parameter int NUM_PERIPH = ier_pkg::NUM_PERIPH,
    parameter int NUM_PIN    = ier_pkg::NUM_PIN,
    parameter int NUM_SLOT   = ier_pkg::NUM_SLOT,
    parameter int SEL_W      = ier_pkg::SEL_W
) (
    input  wire logic                      clk,                  // System clock, 125 MHz.
    input  wire logic                      nrst,                 // Synchronous reset, active low.
    input  wire logic [NUM_PERIPH-1:0]     periph_irq,           // Peripheral request levels.
    input  wire logic [NUM_PIN-1:0]        ext_pin_irq,          // External pin levels.
    input  wire logic [NUM_PIN*2-1:0]      pin_irq_trigger_ctrl, // Two trigger bits per pin.
    input  wire logic [NUM_PIN-1:0]        pin_clear,            // Pin pending clear strobes.
    input  wire logic [NUM_SLOT*SEL_W-1:0] slot_sel,             // Source index per slot.
    input  wire logic [NUM_SLOT-1:0]       slot_to_dtc,          // Slot goes to transfer ctrl.
    input  wire logic [NUM_SLOT-1:0]       slot_accept,          // Slot request taken.
    input  wire logic                      nmi_pin,              // Non-maskable pin level.
    input  wire logic                      nmi_edge_rising,      // Pin edge: 1 rising, 0 falling.
    input  wire logic                      wdt_underflow,        // Independent watchdog underflow.
    input  wire logic                      wdt_refresh_err,      // Independent watchdog refresh error.
    input  wire logic                      voltage_monitor_one,  // Voltage monitor one interrupt.
    input  wire logic                      sram_parity_fault,    // SRAM parity error.
    input  wire logic [ier_pkg::NMI_W-1:0] nmi_clear,            // Cause clear strobes.
    input  wire logic [1:0]                lp_mode,              // Current low power mode.
    input  wire logic [NUM_PERIPH+NUM_PIN-1:0] standby_end_enable, // Wake enables, both words.
    output logic      [NUM_SLOT-1:0]       cpu_vectored_irq_ctrl, // Requests to CPU controller.
    output logic      [NUM_SLOT-1:0]       data_transfer_ctrl,    // Requests to transfer ctrl.
    output logic      [NUM_PIN-1:0]        pin_pending,          // Pending pin edges.
    output logic                           nmi_req,              // Non-maskable request level.
    output logic      [ier_pkg::NMI_W-1:0] nmi_cause,            // Sticky non-maskable causes.
    output logic                           wake_req              // Wake-up request level.
);

    localparam int NUM_SRC = NUM_PERIPH + NUM_PIN;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Picks one source bit; an index past the last source reads as idle.
    function automatic logic src_pick(input logic [NUM_SRC-1:0] vec, input logic [SEL_W-1:0] idx);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (idx == SEL_W'(i)) begin
                hit = vec[i];
            end
        end
        return hit;
    endfunction

    // Edge detect for one pin; the unused code detects nothing.
    function automatic logic edge_hit(input logic [1:0] mode, input logic prev, input logic cur);
        logic hit;
        hit = 1'b0;
        unique case (mode)
            ier_pkg::TRIG_FALL: hit = prev & ~cur;
            ier_pkg::TRIG_RISE: hit = ~prev & cur;
            ier_pkg::TRIG_BOTH: hit = prev ^ cur;
            default:            hit = 1'b0;
        endcase
        return hit;
    endfunction

    // ------------------------------------------------------------
    // Pin sampling and pending state
    // ------------------------------------------------------------
    logic [NUM_PIN-1:0]        pin_prev;
    logic                      nmi_prev;
    logic [NUM_PIN-1:0]        next_pend;
    logic [NUM_SRC-1:0]        src_vec;
    logic [ier_pkg::NMI_W-1:0] next_cause;
    logic [NUM_SLOT-1:0]       slot_hit;
    logic                      next_wake;
    logic [NUM_PIN-1:0]        pin_taken;

    // Previous samples; inputs are already synchronous to clk.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_prev <= ier_pkg::PEND_RST;
            nmi_prev <= 1'b0;
        end else begin
            pin_prev <= ext_pin_irq;
            nmi_prev <= nmi_pin;
        end
    end

    // A pin counts as taken when any slot that selects it is accepted, whichever slot that is.
    always_comb begin
        pin_taken = '0;
        for (int p = 0; p < NUM_PIN; p++) begin
            for (int k = 0; k < NUM_SLOT; k++) begin
                if (slot_accept[k] && slot_sel[k*SEL_W +: SEL_W] == SEL_W'(NUM_PERIPH + p)) begin
                    pin_taken[p] = 1'b1;
                end
            end
        end
    end

    // An edge in the same cycle as a clear or acceptance stays pending.
    always_comb begin
        next_pend = pin_pending;
        for (int p = 0; p < NUM_PIN; p++) begin
            if (pin_taken[p]) begin
                next_pend[p] = 1'b0;
            end
            if (pin_clear[p]) begin
                next_pend[p] = 1'b0;
            end
            if (edge_hit(pin_irq_trigger_ctrl[p*2 +: 2], pin_prev[p], ext_pin_irq[p])) begin
                next_pend[p] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_pending <= ier_pkg::PEND_RST;
        end else begin
            pin_pending <= next_pend;
        end
    end

    // ------------------------------------------------------------
    // Slot routing
    // ------------------------------------------------------------

    assign src_vec = {pin_pending, periph_irq};

    // Each slot sees its chosen source level.
    always_comb begin
        for (int k = 0; k < NUM_SLOT; k++) begin
            slot_hit[k] = src_pick(src_vec, slot_sel[k*SEL_W +: SEL_W]);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cpu_vectored_irq_ctrl <= '0;
            data_transfer_ctrl    <= '0;
        end else begin
            cpu_vectored_irq_ctrl <= slot_hit & ~slot_to_dtc;
            data_transfer_ctrl    <= slot_hit & slot_to_dtc;
        end
    end

    // ------------------------------------------------------------
    // Non-maskable causes
    // ------------------------------------------------------------

    // Causes are sticky so that a one-cycle fault is never missed; set wins over clear.
    always_comb begin
        next_cause = nmi_cause & ~nmi_clear;
        if (nmi_edge_rising ? (~nmi_prev & nmi_pin) : (nmi_prev & ~nmi_pin)) begin
            next_cause[ier_pkg::NMI_PIN_BIT] = 1'b1;
        end
        if (wdt_underflow || wdt_refresh_err) begin
            next_cause[ier_pkg::NMI_WDT_BIT] = 1'b1;
        end
        if (voltage_monitor_one) begin
            next_cause[ier_pkg::NMI_LVD_BIT] = 1'b1;
        end
        if (sram_parity_fault) begin
            next_cause[ier_pkg::NMI_PAR_BIT] = 1'b1;
        end
    end

    // Request follows the causes in the same edge.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            nmi_cause <= ier_pkg::NMI_RST;
            nmi_req   <= 1'b0;
        end else begin
            nmi_cause <= next_cause;
            nmi_req   <= |next_cause;
        end
    end

    // ------------------------------------------------------------
    // Wake-up control
    // ------------------------------------------------------------

    // Wake is judged on current pending state, so it lags an event by one cycle.
    always_comb begin
        next_wake = 1'b0;
        unique case (lp_mode)
            ier_pkg::LP_RUN:     next_wake = 1'b0;
            ier_pkg::LP_SLEEP:   next_wake = (|src_vec) | (|nmi_cause);
            ier_pkg::LP_STANDBY,
            ier_pkg::LP_SNOOZE:  next_wake = (|(src_vec & standby_end_enable)) | (|nmi_cause);
        endcase
    end

    // Registered wake request.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= next_wake;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_fall0;
        ext_pin_irq[0] ##1 !ext_pin_irq[0] && pin_irq_trigger_ctrl[1:0] == ier_pkg::TRIG_FALL;
    endsequence

    sequence s_rise0;
        !ext_pin_irq[0] ##1 ext_pin_irq[0] && pin_irq_trigger_ctrl[1:0] == ier_pkg::TRIG_RISE;
    endsequence

    property p_fall_pend;
        @(posedge clk) disable iff (!nrst) s_fall0 |=> pin_pending[0];
    endproperty
    a_fall_pend: assert property (p_fall_pend) else $error("Falling edge not pending.");

    property p_rise_only;
        @(posedge clk) disable iff (!nrst)
            (ext_pin_irq[0] ##1 !ext_pin_irq[0] && pin_irq_trigger_ctrl[1:0] == ier_pkg::TRIG_RISE
             && !pin_pending[0]) |=> !pin_pending[0];
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("Rising mode took a falling edge.");

    property p_rise_route;
        @(posedge clk) disable iff (!nrst)
            s_rise0 ##1 (slot_sel[5*SEL_W +: SEL_W] == SEL_W'(NUM_PERIPH) && !slot_to_dtc[5])
            |=> cpu_vectored_irq_ctrl[5];
    endproperty
    a_rise_route: assert property (p_rise_route) else $error("Pin edge not routed to slot.");

    property p_hold;
        @(posedge clk) disable iff (!nrst)
            pin_pending[0] && !pin_clear[0] && !pin_taken[0] |=> pin_pending[0];
    endproperty
    a_hold: assert property (p_hold) else $error("Pending pin dropped without cause.");

    property p_cpu_route;
        @(posedge clk) disable iff (!nrst)
            src_pick(src_vec, slot_sel[SEL_W-1:0]) && !slot_to_dtc[0]
            |=> cpu_vectored_irq_ctrl[0] && !data_transfer_ctrl[0];
    endproperty
    a_cpu_route: assert property (p_cpu_route) else $error("Slot not sent to CPU.");

    property p_dtc_route;
        @(posedge clk) disable iff (!nrst)
            src_pick(src_vec, slot_sel[SEL_W-1:0]) && slot_to_dtc[0]
            |=> data_transfer_ctrl[0] && !cpu_vectored_irq_ctrl[0];
    endproperty
    a_dtc_route: assert property (p_dtc_route) else $error("Slot not sent to transfer ctrl.");

    property p_periph_last;
        @(posedge clk) disable iff (!nrst)
            periph_irq[NUM_PERIPH-1] && slot_sel[(NUM_SLOT-1)*SEL_W +: SEL_W] == SEL_W'(NUM_PERIPH-1)
            && !slot_to_dtc[NUM_SLOT-1] |=> cpu_vectored_irq_ctrl[NUM_SLOT-1];
    endproperty
    a_periph_last: assert property (p_periph_last) else $error("Last peripheral not routed.");

    property p_nmi_pin;
        @(posedge clk) disable iff (!nrst)
            (!nmi_pin ##1 nmi_pin && nmi_edge_rising) |=> nmi_req && nmi_cause[ier_pkg::NMI_PIN_BIT];
    endproperty
    a_nmi_pin: assert property (p_nmi_pin) else $error("Pin edge raised no NMI.");

    property p_wdt;
        @(posedge clk) disable iff (!nrst)
            wdt_refresh_err |=> nmi_req && nmi_cause[ier_pkg::NMI_WDT_BIT];
    endproperty
    a_wdt: assert property (p_wdt) else $error("Watchdog fault raised no NMI.");

    property p_lvd;
        @(posedge clk) disable iff (!nrst)
            voltage_monitor_one |=> nmi_req ##1 nmi_cause[ier_pkg::NMI_LVD_BIT] || $past(nmi_clear[2]);
    endproperty
    a_lvd: assert property (p_lvd) else $error("Voltage monitor raised no NMI.");

    property p_parity;
        @(posedge clk) disable iff (!nrst)
            sram_parity_fault && nmi_clear[ier_pkg::NMI_PAR_BIT] |=> nmi_cause[ier_pkg::NMI_PAR_BIT];
    endproperty
    a_parity: assert property (p_parity) else $error("Parity fault lost to clear.");

    property p_wake_sleep;
        @(posedge clk) disable iff (!nrst)
            lp_mode == ier_pkg::LP_SLEEP && (|src_vec) |=> wake_req;
    endproperty
    a_wake_sleep: assert property (p_wake_sleep) else $error("Sleep did not wake.");

    property p_wake_standby;
        @(posedge clk) disable iff (!nrst)
            lp_mode == ier_pkg::LP_STANDBY && !(|(src_vec & standby_end_enable)) && !(|nmi_cause)
            |=> !wake_req;
    endproperty
    a_wake_standby: assert property (p_wake_standby) else $error("Standby woke unenabled.");

endmodule

// ### src/ier_pkg.sv
package ier_pkg;
    // ------------------------------------------------------------
    // Source counts and widths
    // ------------------------------------------------------------
    localparam int NUM_PERIPH = 33;                    // Peripheral interrupt sources.
    localparam int NUM_PIN    = 6;                     // External pin interrupt inputs.
    localparam int NUM_SLOT   = 39;                    // Request lines toward the CPU controller.
    localparam int NUM_SRC    = NUM_PERIPH + NUM_PIN;  // Selectable sources.
    localparam int SEL_W      = 6;                     // Width of one slot source index.
    localparam int PIN_BASE   = NUM_PERIPH;            // Source index of pin 0.

    // ------------------------------------------------------------
    // Pin trigger encodings
    // ------------------------------------------------------------
    localparam logic [1:0] TRIG_FALL = 2'h0;
    localparam logic [1:0] TRIG_RISE = 2'h1;
    localparam logic [1:0] TRIG_BOTH = 2'h2;

    // ------------------------------------------------------------
    // Low power mode encodings
    // ------------------------------------------------------------
    localparam logic [1:0] LP_RUN     = 2'h0;
    localparam logic [1:0] LP_SLEEP   = 2'h1;
    localparam logic [1:0] LP_STANDBY = 2'h2;
    localparam logic [1:0] LP_SNOOZE  = 2'h3;

    // ------------------------------------------------------------
    // Non-maskable cause bit positions and reset values
    // ------------------------------------------------------------
    localparam int NMI_W       = 4;
    localparam int NMI_PIN_BIT = 0;
    localparam int NMI_WDT_BIT = 1;
    localparam int NMI_LVD_BIT = 2;
    localparam int NMI_PAR_BIT = 3;
    localparam logic [NMI_W-1:0] NMI_RST = 4'h0;
    localparam logic [NUM_PIN-1:0] PEND_RST = 6'h00;
endpackage

// ### testbench/ier_irq_taker.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Request taker standing for the CPU and transfer controllers
// ------------------------------------------------------------
module ier_irq_taker (
    input  wire logic                           clk,         // System clock.
    input  wire logic                           nrst,        // Synchronous reset, active low.
    input  wire logic                           take_en,     // Accept requests while high.
    input  wire logic [ier_pkg::NUM_SLOT-1:0]   cpu_req,     // Slot levels toward the CPU controller.
    input  wire logic [ier_pkg::NUM_SLOT-1:0]   dtc_req,     // Slot levels toward the transfer controller.
    output logic      [ier_pkg::NUM_SLOT-1:0]   slot_accept  // One-cycle accept pulses.
);
    // A seen request is taken one cycle later; the pulse is dropped every other cycle so that a level
    // which has not yet fallen is acknowledged again, as a busy controller may do.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            slot_accept <= '0;
        end else begin
            slot_accept <= {ier_pkg::NUM_SLOT{take_en}} & (cpu_req | dtc_req) & ~slot_accept;
        end
    end
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
    logic         clk = 1'b0, nrst = 1'b0, take_en = 1'b0;
    logic [32:0]  periph_irq = '0;
    logic [5:0]   ext_pin_irq = '0, pin_clear = '0, pin_pending;
    logic [11:0]  trig = 12'hfff;
    logic [233:0] slot_sel = '1;
    logic [38:0]  slot_to_dtc = '0, slot_accept, cpu_out, dtc_out, standby_end_enable = '0;
    logic         nmi_pin = 1'b0, nmi_edge_rising = 1'b1, wdt_underflow = 1'b0, wdt_refresh_err = 1'b0;
    logic         voltage_monitor_one = 1'b0, sram_parity_fault = 1'b0, nmi_req, wake_req;
    logic [3:0]   nmi_clear = '0, nmi_cause;
    logic [1:0]   lp_mode = 2'h0;
    int           bad_count = 0, samples_checked = 0;

    // The clock toggles every 4 ns, half of its 8 ns period.
    always #4 clk = ~clk;

    ier_event_router i_dut (.clk(clk), .nrst(nrst), .periph_irq(periph_irq), .ext_pin_irq(ext_pin_irq),
        .pin_irq_trigger_ctrl(trig), .pin_clear(pin_clear), .slot_sel(slot_sel), .slot_to_dtc(slot_to_dtc),
        .slot_accept(slot_accept), .nmi_pin(nmi_pin), .nmi_edge_rising(nmi_edge_rising),
        .wdt_underflow(wdt_underflow), .wdt_refresh_err(wdt_refresh_err),
        .voltage_monitor_one(voltage_monitor_one), .sram_parity_fault(sram_parity_fault),
        .nmi_clear(nmi_clear), .lp_mode(lp_mode), .standby_end_enable(standby_end_enable),
        .cpu_vectored_irq_ctrl(cpu_out), .data_transfer_ctrl(dtc_out), .pin_pending(pin_pending),
        .nmi_req(nmi_req), .nmi_cause(nmi_cause), .wake_req(wake_req));

    ier_irq_taker i_taker (.clk(clk), .nrst(nrst), .take_en(take_en), .cpu_req(cpu_out), .dtc_req(dtc_out),
        .slot_accept(slot_accept));

    // Waits n edges, then lets the edge's updates land before anything is sampled.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string name, input logic [38:0] exp, input logic [38:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic pin_clr(input int p);
        @(posedge clk);
        pin_clear[p] <= 1'b1;
        @(posedge clk);
        pin_clear[p] <= 1'b0;
    endtask

    task automatic nmi_clr();
        @(posedge clk);
        nmi_clear <= 4'hf;
        @(posedge clk);
        nmi_clear <= 4'h0;
    endtask

    // Peripheral levels reach the first, a middle and the last slot; the first slot goes both ways.
    task automatic t_route();
        int k;
        int s;
        for (int i = 0; i < 4; i++) begin
            k = (i % 3) * 19;
            s = (i % 3) * 16;
            @(posedge clk);
            slot_sel[k*6 +: 6] <= 6'(s);
            slot_to_dtc[k] <= i[0];
            periph_irq <= 33'h1 << s;
            settle(3);
            chk("cpu_route", i[0] ? 39'h0 : 39'h1 << k, cpu_out);
            chk("dtc_route", i[0] ? 39'h1 << k : 39'h0, dtc_out);
            @(posedge clk);
            periph_irq <= '0;
            settle(3);
            chk("route_off", 39'h0, cpu_out | dtc_out);
            @(posedge clk);
            slot_sel[k*6 +: 6] <= 6'h3f;
            slot_to_dtc[k] <= 1'b0;
        end
    endtask

    // Every pin in every trigger mode sees one rising and one falling edge.
    task automatic t_pins();
        for (int p = 0; p < 6; p++) begin
            for (int m = 0; m < 4; m++) begin
                @(posedge clk);
                trig[2*p +: 2] <= m[1:0];
                slot_sel[30 +: 6] <= 6'(33 + p);
                settle(3);
                pin_clr(p);
                @(posedge clk);
                ext_pin_irq[p] <= 1'b1;
                settle(4);
                chk("pend_rise", 39'(m == 1 || m == 2), 39'(pin_pending[p]));
                pin_clr(p);
                @(posedge clk);
                ext_pin_irq[p] <= 1'b0;
                settle(4);
                chk("pend_fall", 39'(m == 0 || m == 2), 39'(pin_pending[p]));
                if (m == 0) begin
                    @(posedge clk);
                    slot_sel[30 +: 6] <= 6'(33 + p);
                    settle(3);
                    chk("pin_route", 39'h20, cpu_out);
                    @(posedge clk);
                    take_en <= 1'b1;
                    settle(4);
                    chk("pend_taken", 39'h0, 39'(pin_pending));
                    @(posedge clk);
                    take_en <= 1'b0;
                    slot_sel[30 +: 6] <= 6'h3f;
                end
                pin_clr(p);
                @(posedge clk);
                trig[2*p +: 2] <= 2'h3;
                slot_sel[30 +: 6] <= 6'h3f;
            end
        end
    endtask

    // Each non-maskable cause in turn, the pin first rising then falling; the parity fault meets a clear
    // in the same cycle and must win over it.
    task automatic t_nmi();
        int b;
        for (int i = 0; i < 6; i++) begin
            b = (i == 0 || i == 5) ? 0 : (i <= 2) ? 1 : i - 1;
            @(posedge clk);
            case (i)
                0: nmi_pin <= 1'b1;
                1: wdt_underflow <= 1'b1;
                2: wdt_refresh_err <= 1'b1;
                3: voltage_monitor_one <= 1'b1;
                4: begin
                    sram_parity_fault <= 1'b1;
                    nmi_clear <= 4'hf;
                end
                default: begin
                    nmi_edge_rising <= 1'b0;
                    nmi_pin <= 1'b0;
                end
            endcase
            @(posedge clk);
            {wdt_underflow, wdt_refresh_err, voltage_monitor_one, sram_parity_fault} <= 4'h0;
            nmi_clear <= 4'h0;
            settle(3);
            chk("nmi_cause", 39'h1 << b, 39'(nmi_cause));
            chk("nmi_req", 39'h1, 39'(nmi_req));
            nmi_clr();
            settle(2);
            chk("nmi_cleared", 39'h0, 39'({nmi_req, nmi_cause}));
        end
    endtask

    // Wake-up across run, sleep, standby and snooze with and without enables.
    task automatic t_wake();
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            lp_mode <= (i == 0) ? ier_pkg::LP_RUN : (i == 1) ? ier_pkg::LP_SLEEP :
                       (i < 4) ? ier_pkg::LP_STANDBY : ier_pkg::LP_SNOOZE;
            periph_irq <= (i < 5) ? 33'h10 : 33'h0;
            standby_end_enable <= (i == 0 || i == 3 || i == 4) ? 39'h10 : 39'h0;
            sram_parity_fault <= (i == 5);
            @(posedge clk);
            sram_parity_fault <= 1'b0;
            settle(3);
            chk("wake_req", 39'(i == 1 || i == 3 || i == 4 || i == 5), 39'(wake_req));
            nmi_clr();
        end
        @(posedge clk);
        periph_irq <= '0;
        lp_mode <= ier_pkg::LP_RUN;
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Main sequence after a reset held for 16 cycles.
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        settle(1);
        chk("reset_outs", 39'h0, cpu_out | dtc_out | 39'({pin_pending, nmi_cause, nmi_req, wake_req}));
        t_route();
        t_pins();
        t_nmi();
        t_wake();
        wrap_up();
    end

    // A hang is cut short well beyond the expected run of about 720 cycles.
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up();
    end
endmodule
